// ==== mdsr_pkg.sv ====
// Package for the motor driver status register group
package mdsr_pkg;

  // Register word and address widths
  localparam int MDSR_DW = 16;
  localparam int MDSR_AW = 8;

  // Register offsets (word index)
  localparam logic [7:0] MDSR_OFS_SUMMARY = 8'h00;
  localparam logic [7:0] MDSR_OFS_TEMP = 8'h04;
  localparam logic [7:0] MDSR_OFS_SUPPLY = 8'h05;
  localparam logic [7:0] MDSR_OFS_DRIVER = 8'h06;

  // Reset values
  localparam logic [15:0] MDSR_RST_SUMMARY = 16'h0080;
  localparam logic [15:0] MDSR_RST_TEMP = 16'h0000;
  localparam logic [15:0] MDSR_RST_SUPPLY = 16'h0000;
  localparam logic [15:0] MDSR_RST_DRIVER = 16'h0000;
  localparam logic [15:0] MDSR_ZERO = 16'h0000;

  // Field positions
  localparam int MDSR_B_PARITY = 15;
  localparam int MDSR_B_NVLOAD = 8;
  localparam int MDSR_B_POR = 7;
  localparam int MDSR_B_COMM = 6;
  localparam int MDSR_B_OCP = 5;
  localparam int MDSR_B_UV = 2;
  localparam int MDSR_B_OT = 1;
  localparam int MDSR_B_FAULT = 0;
  localparam int MDSR_B_REG_TSD = 2;
  localparam int MDSR_B_TWARN = 1;
  localparam int MDSR_B_TSD = 0;
  localparam int MDSR_B_SREF_UV = 5;
  localparam int MDSR_B_PUMP_UV = 4;
  localparam int MDSR_B_ROUT_UV = 2;
  localparam int MDSR_B_RIN_UV = 0;

  // Driver word: per-switch overcurrent in the low seven bits except bit 3, others reserved
  localparam int MDSR_DRV_W = 7;
  localparam logic [6:0] MDSR_DRV_MASK = 7'h77;

  // Raw condition inputs from the analog and control sections
  typedef struct packed {
    logic nonvolatile_load_fault;
    logic serial_comm_fault;
    logic thermal_warning;
    logic thermal_shutdown;
    logic regulator_thermal_shutdown;
    logic sense_reference_undervoltage;
    logic pump_undervoltage;
    logic regulator_output_undervoltage;
    logic regulator_input_undervoltage;
    logic [6:0] driver_overcurrent;
  } mdsr_cond_t;

  // Register access port request: read and write strobes, address, write data
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } mdsr_req_t;

  // Even parity over the low fifteen bits, placed in bit 15
  function automatic logic [15:0] mdsr_with_parity(input logic [15:0] w, input logic en);
    logic [15:0] r;
    r = w;
    r[MDSR_B_PARITY] = en ? (^w[14:0]) : 1'b0;
    return r;
  endfunction

endpackage

// ==== mdsr_sync.sv ====
// Two-stage synchroniser for a bundle of condition levels
`timescale 1ns/1ps
module mdsr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Levels
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_r;
  logic [W-1:0] s2_nxt;

  // Next values, held while clock enable is low
  always_comb begin
    s1_nxt = i_ce ? i_d : s1_r;
    s2_nxt = i_ce ? s1_r : s2_r;
  end

  // Registers
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign o_q = s2_r;
endmodule

// ==== mdsr_top.sv ====
// Read-only status register group of a three-phase motor driver
`timescale 1ns/1ps

module mdsr_top (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Configuration
  input wire logic i_parity_check_enable,
  // Raw conditions from outside the clock domain
  input wire mdsr_pkg::mdsr_cond_t i_cond,
  // Power-on reset clear request, one-cycle pulse from serial logic
  input wire logic i_por_clear,
  // Register access port from the serial frame logic
  input wire mdsr_pkg::mdsr_req_t i_req,
  input wire logic i_load_rd_ptr,
  input wire logic i_load_wr_ptr,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic [7:0] o_rd_ptr,
  output logic [7:0] o_wr_ptr,
  // Summary outputs
  output logic o_fault
);
  import mdsr_pkg::*;

  localparam int CW = $bits(mdsr_cond_t);

  // Next pointer value, shared by both pointers
  // Wraps past 8'hff back to zero, not at the last offset
  function automatic logic [7:0] ptr_step(input logic [7:0] p);
    return p + 8'h01;
  endfunction

  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_s1_nxt;
  logic rst_s2_nxt;
  logic rst_b;
  mdsr_cond_t cond_s;
  logic pen_s;
  logic [15:0] summary_r;
  logic [15:0] summary_nxt;
  logic [15:0] temp_r;
  logic [15:0] temp_nxt;
  logic [15:0] supply_r;
  logic [15:0] supply_nxt;
  logic [15:0] driver_r;
  logic [15:0] driver_nxt;
  logic por_r;
  logic por_nxt;
  logic [7:0] rd_ptr_r;
  logic [7:0] rd_ptr_nxt;
  logic [7:0] wr_ptr_r;
  logic [7:0] wr_ptr_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [15:0] sel_word;
  logic any_uv;
  logic any_ot;
  logic any_fault;
  logic word_done;

  // Reset release shift: a one walks in behind the pin
  // Not gated by the enable, so reset always ends
  always_comb begin
    rst_s1_nxt = 1'b1;
    rst_s2_nxt = rst_s1_r;
  end

  // Reset release through two flip-flops
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= rst_s1_nxt;
      rst_s2_r <= rst_s2_nxt;
    end
  end
  assign rst_b = rst_s2_r;

  // Condition and configuration pins synchronised
  mdsr_sync #(.W(CW + 1)) u_sync (
    .i_mclk(i_mclk),
    .i_rst_b(rst_b),
    .i_ce(i_ce),
    .i_d({i_cond, i_parity_check_enable}),
    .o_q({cond_s, pen_s})
  );

  // Summary fault combinations
  always_comb begin
    any_uv = cond_s.pump_undervoltage | cond_s.regulator_output_undervoltage
           | cond_s.regulator_input_undervoltage;
    any_ot = cond_s.thermal_warning | cond_s.thermal_shutdown
           | cond_s.regulator_thermal_shutdown;
    any_fault = any_uv | any_ot | cond_s.nonvolatile_load_fault
              | cond_s.serial_comm_fault | (|cond_s.driver_overcurrent)
              | cond_s.regulator_thermal_shutdown
              | cond_s.sense_reference_undervoltage;
  end

  // A word is taken on an enabled edge with a strobe
  // Both strobes count alike: a write still returns read data
  assign word_done = i_ce && (i_req.rd || i_req.wr);

  // Power-on reset flag: set at reset, cleared on request
  always_comb begin
    por_nxt = por_r;
    if (i_ce && i_por_clear) begin
      por_nxt = 1'b0;
    end
  end

  // Power-on flag register
  // Only reset sets it; the host clears it once seen
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      por_r <= 1'b1;
    end else begin
      por_r <= por_nxt;
    end
  end

  // Summary word next value, frozen while disabled
  always_comb begin
    summary_nxt = summary_r;
    if (i_ce) begin
      // Live levels, not sticky, except the held power-on flag; reserved bits stay zero
      summary_nxt = MDSR_ZERO;
      summary_nxt[MDSR_B_NVLOAD] = cond_s.nonvolatile_load_fault;
      summary_nxt[MDSR_B_POR] = por_nxt;
      summary_nxt[MDSR_B_COMM] = cond_s.serial_comm_fault;
      summary_nxt[MDSR_B_OCP] = |cond_s.driver_overcurrent;
      summary_nxt[MDSR_B_UV] = any_uv;
      summary_nxt[MDSR_B_OT] = any_ot;
      summary_nxt[MDSR_B_FAULT] = any_fault;
    end
  end

  // Summary word register
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      summary_r <= MDSR_RST_SUMMARY;
    end else begin
      summary_r <= summary_nxt;
    end
  end

  // Temperature word next value
  always_comb begin
    temp_nxt = temp_r;
    if (i_ce) begin
      temp_nxt = MDSR_ZERO;
      temp_nxt[MDSR_B_REG_TSD] = cond_s.regulator_thermal_shutdown;
      temp_nxt[MDSR_B_TWARN] = cond_s.thermal_warning;
      temp_nxt[MDSR_B_TSD] = cond_s.thermal_shutdown;
    end
  end

  // Temperature word register
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      temp_r <= MDSR_RST_TEMP;
    end else begin
      temp_r <= temp_nxt;
    end
  end

  // Supply word next value
  always_comb begin
    supply_nxt = supply_r;
    if (i_ce) begin
      // Sense reference undervoltage stays out of the summary UV bit but sets the fault bit
      supply_nxt = MDSR_ZERO;
      supply_nxt[MDSR_B_SREF_UV] = cond_s.sense_reference_undervoltage;
      supply_nxt[MDSR_B_PUMP_UV] = cond_s.pump_undervoltage;
      supply_nxt[MDSR_B_ROUT_UV] = cond_s.regulator_output_undervoltage;
      supply_nxt[MDSR_B_RIN_UV] = cond_s.regulator_input_undervoltage;
    end
  end

  // Supply word register
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      supply_r <= MDSR_RST_SUPPLY;
    end else begin
      supply_r <= supply_nxt;
    end
  end

  // Driver word next value
  always_comb begin
    driver_nxt = driver_r;
    if (i_ce) begin
      // Bit 3 stays reserved through the mask
      driver_nxt = MDSR_ZERO;
      driver_nxt[MDSR_DRV_W-1:0] = cond_s.driver_overcurrent & MDSR_DRV_MASK;
    end
  end

  // Driver word register
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      driver_r <= MDSR_RST_DRIVER;
    end else begin
      driver_r <= driver_nxt;
    end
  end

  // Word select by read pointer; unlisted offsets read zero
  always_comb begin
    case (rd_ptr_r)
      MDSR_OFS_SUMMARY: sel_word = summary_r;
      MDSR_OFS_TEMP: sel_word = temp_r;
      MDSR_OFS_SUPPLY: sel_word = supply_r;
      MDSR_OFS_DRIVER: sel_word = driver_r;
      default: sel_word = MDSR_ZERO;
    endcase
  end

  // Pointer next values
  always_comb begin
    rd_ptr_nxt = rd_ptr_r;
    wr_ptr_nxt = wr_ptr_r;
    if (i_ce) begin
      // A header load wins over a word on the same pointer
      if (i_load_rd_ptr) begin
        rd_ptr_nxt = i_req.addr;
      end else if (word_done) begin
        rd_ptr_nxt = ptr_step(rd_ptr_r);
      end
      if (i_load_wr_ptr) begin
        wr_ptr_nxt = i_req.addr;
      end else if (word_done) begin
        wr_ptr_nxt = ptr_step(wr_ptr_r);
      end
      // Write data is discarded: all words here are read-only
    end
  end

  // Pointer registers
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr_r <= MDSR_OFS_SUMMARY;
      wr_ptr_r <= MDSR_OFS_SUMMARY;
    end else begin
      rd_ptr_r <= rd_ptr_nxt;
      wr_ptr_r <= wr_ptr_nxt;
    end
  end

  // Read data next values: word at the read pointer, parity added
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    // A header alone returns no word; the pulse lasts one cycle
    if (word_done && !i_load_rd_ptr) begin
      rdata_nxt = mdsr_with_parity(sel_word, pen_s);
      rvalid_nxt = 1'b1;
    end
  end

  // Read data registers
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= MDSR_ZERO;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Outputs
  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_rd_ptr = rd_ptr_r;
  assign o_wr_ptr = wr_ptr_r;
  assign o_fault = summary_r[MDSR_B_FAULT];
endmodule

// ==== mdsr_chk.sv ====
// Port-level assertion checker for the status register group
`timescale 1ns/1ps
module mdsr_chk (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Inputs watched
  input wire mdsr_pkg::mdsr_cond_t i_cond,
  input wire mdsr_pkg::mdsr_req_t i_req,
  input wire logic i_load_rd_ptr,
  input wire logic i_load_wr_ptr,
  // Outputs watched
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic [7:0] o_rd_ptr,
  input wire logic [7:0] o_wr_ptr,
  input wire logic o_fault
);
  import mdsr_pkg::*;
  logic take;
  // Word taken at this edge
  assign take = i_ce && (i_req.rd || i_req.wr);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  AST_ANSWER: assert property (take && !i_load_rd_ptr |=> o_rvalid)
    else $error("word without answer");
  AST_NO_SPUR: assert property (!take |=> !o_rvalid)
    else $error("answer without word");
  AST_RD_INC: assert property (take && !i_load_rd_ptr |=> o_rd_ptr == $past(o_rd_ptr) + 8'h01)
    else $error("read pointer not advanced");
  AST_WR_INC: assert property (take && !i_load_wr_ptr |=> o_wr_ptr == $past(o_wr_ptr) + 8'h01)
    else $error("write pointer not advanced");
  AST_RD_LOAD: assert property (i_ce && i_load_rd_ptr |=> o_rd_ptr == $past(i_req.addr))
    else $error("read pointer not loaded");
  AST_PARITY: assert property (o_rvalid |-> !o_rdata[15] || !(^o_rdata))
    else $error("bad parity bit");
  AST_TEMP_RSVD: assert property (o_rvalid && $past(o_rd_ptr) == 8'h04 |-> o_rdata[14:3] == 12'h000)
    else $error("reserved temperature bits set");
  AST_UNMAPPED: assert property (o_rvalid && $past(o_rd_ptr) inside {[8'h01:8'h03]} |-> !o_rdata)
    else $error("unmapped word not zero");
  AST_FAULT_QUIET: assert property ((i_ce && i_cond == 16'h0000) [*4] |-> !o_fault)
    else $error("fault without condition");
  // Main scenarios
  cover property (o_rvalid && o_rdata[15]);
  cover property (i_ce && i_load_rd_ptr);
  cover property ($rose(o_fault));
endmodule
bind mdsr_top mdsr_chk i_chk (.i_mclk, .i_rst_b, .i_ce, .i_cond, .i_req, .i_load_rd_ptr,
  .i_load_wr_ptr, .o_rdata, .o_rvalid, .o_rd_ptr, .o_wr_ptr, .o_fault);

// ==== mdsr_host.sv ====
// Host model issuing headers and 16-bit words
`timescale 1ns/1ps
module mdsr_host (
  // Clock
  input wire logic i_mclk,
  // Requests
  output mdsr_pkg::mdsr_req_t o_req,
  output logic o_load_rd_ptr,
  output logic o_load_wr_ptr,
  output logic o_por_clear,
  // Answers
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid
);
  import mdsr_pkg::*;
  // Idle levels at time zero
  initial begin
    o_req = '0;
    o_load_rd_ptr = 1'b0;
    o_load_wr_ptr = 1'b0;
    o_por_clear = 1'b0;
  end
  // Address header loads both pointers
  task automatic header(input logic [7:0] a);
    @(posedge i_mclk);
    o_req.addr <= a;
    o_load_rd_ptr <= 1'b1;
    o_load_wr_ptr <= 1'b1;
    @(posedge i_mclk);
    o_load_rd_ptr <= 1'b0;
    o_load_wr_ptr <= 1'b0;
  endtask
  // One whole word, read data one cycle later
  task automatic word(input logic wr, output logic [15:0] d);
    @(posedge i_mclk);
    o_req.rd <= !wr;
    o_req.wr <= wr;
    o_req.wdata <= 16'hffff;
    @(posedge i_mclk);
    o_req.rd <= 1'b0;
    o_req.wr <= 1'b0;
    o_req.wdata <= 16'h0000;
    @(negedge i_mclk);
    d = i_rvalid ? i_rdata : 16'hxxxx;
  endtask
  // Power-on flag clear pulse
  task automatic clear_por();
    @(posedge i_mclk);
    o_por_clear <= 1'b1;
    @(posedge i_mclk);
    o_por_clear <= 1'b0;
  endtask
endmodule

// ==== tb_motor_driver_status_registers.sv ====
// Self-checking testbench for the status register group
`timescale 1ns/1ps
module tb_motor_driver_status_registers;
  import mdsr_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ce = 1'b1;
  logic i_parity_check_enable = 1'b0;
  mdsr_cond_t i_cond = '0;
  mdsr_req_t i_req;
  logic i_por_clear, i_load_rd_ptr, i_load_wr_ptr, o_rvalid, o_fault, por = 1'b1;
  logic [15:0] o_rdata;
  logic [7:0] o_rd_ptr, o_wr_ptr;
  int miscompares = 0;
  int samples_checked = 0;
  // Clock
  always #10 i_mclk = ~i_mclk;
  mdsr_top i_dut (.i_mclk, .i_rst_b, .i_ce, .i_parity_check_enable, .i_cond, .i_por_clear,
    .i_req, .i_load_rd_ptr, .i_load_wr_ptr, .o_rdata, .o_rvalid, .o_rd_ptr, .o_wr_ptr, .o_fault);
  mdsr_host i_host (.i_mclk, .o_req(i_req), .o_load_rd_ptr(i_load_rd_ptr),
    .o_load_wr_ptr(i_load_wr_ptr), .o_por_clear(i_por_clear), .i_rdata(o_rdata),
    .i_rvalid(o_rvalid));
  // Compare one word
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compare one pin level
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Expected word at an offset
  function automatic logic [15:0] exp_word(input logic [7:0] a, input mdsr_cond_t c);
    logic [15:0] w;
    case (a)
      8'h00: w = {7'h0, c.nonvolatile_load_fault, por, c.serial_comm_fault,
        |c.driver_overcurrent, 2'b00, c.pump_undervoltage | c.regulator_output_undervoltage |
        c.regulator_input_undervoltage, c.thermal_warning | c.thermal_shutdown |
        c.regulator_thermal_shutdown, |c};
      8'h04: w = {13'h0, c.regulator_thermal_shutdown, c.thermal_warning, c.thermal_shutdown};
      8'h05: w = {10'h0, c.sense_reference_undervoltage, c.pump_undervoltage, 1'b0,
        c.regulator_output_undervoltage, 1'b0, c.regulator_input_undervoltage};
      8'h06: w = {9'h0, c.driver_overcurrent & 7'h77};
      default: w = 16'h0000;
    endcase
    if (i_parity_check_enable) w[15] = ^w[14:0];
    return w;
  endfunction
  // Burst read of offsets 0 to 6
  task automatic scan(input string what);
    logic [15:0] d;
    @(negedge i_mclk);
    chk_bit("fault pin", |i_cond, o_fault);
    i_host.header(8'h00);
    for (int a = 0; a < 7; a++) begin
      i_host.word(1'b0, d);
      chk(what, exp_word(8'(a), i_cond), d);
    end
    chk("read pointer after burst", 16'h0007, {8'h00, o_rd_ptr});
  endtask
  // Each condition alone except driver overcurrent bit 3, parity off then on
  task automatic t_conditions();
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 16; k++) begin
        if (k != 3) begin
          @(posedge i_mclk);
          i_cond <= mdsr_cond_t'(16'h0001 << k);
          i_parity_check_enable <= p[0];
          repeat (5) @(posedge i_mclk);
          scan("condition word");
        end
      end
    end
    @(posedge i_mclk);
    i_cond <= '0;
    repeat (5) @(posedge i_mclk);
  endtask
  // Clock enable low freezes the status words
  task automatic t_freeze();
    @(posedge i_mclk);
    i_ce <= 1'b0;
    i_cond <= mdsr_cond_t'(16'h8000);
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    chk_bit("fault while frozen", 1'b0, o_fault);
    @(posedge i_mclk);
    i_ce <= 1'b1;
    repeat (5) @(posedge i_mclk);
    scan("after freeze");
    @(posedge i_mclk);
    i_cond <= '0;
    repeat (5) @(posedge i_mclk);
  endtask
  // Reset in mid-run brings the power-on flag back
  task automatic t_reset();
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_mclk);
    por = 1'b1;
    chk("pointers after reset", 16'h0000, {o_rd_ptr, o_wr_ptr});
    scan("second reset");
  endtask
  // Write ignored, write pointer advances
  task automatic t_write();
    logic [15:0] d;
    i_host.header(8'h00);
    i_host.word(1'b1, d);
    chk("data during write", exp_word(8'h00, i_cond), d);
    chk("write pointer", {8'h00, 8'h01}, {8'h00, o_wr_ptr});
    scan("after write");
  endtask
  // Run
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_mclk);
    scan("reset word");
    t_conditions();
    t_write();
    t_freeze();
    i_host.clear_por();
    por = 1'b0;
    scan("cleared power-on");
    t_reset();
    results();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge i_mclk);
    miscompares++;
    results();
  end
  // Verdict
  task automatic results();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
endmodule
